// [psm_pkg.sv]
// ==========================================================
// power save mode control: shared constants and types
// ==========================================================
package psm_pkg;

  // ========================================================
  // register map (byte addresses on the register bus)
  // ========================================================
  localparam logic [7:0] PCTRL_OFF = 8'h00;
  localparam logic [7:0] PSTAT_OFF = 8'h04;

  // ========================================================
  // power control register fields
  // ========================================================
  localparam int IDLE_BIT = 0;
  localparam int PD_BIT = 1;
  localparam int GF0_BIT = 2;
  localparam int GF1_BIT = 3;
  localparam logic [3:0] PCTRL_RST = 4'h0;

  // ========================================================
  // status register fields
  // ========================================================
  localparam int ST_IDLE_BIT = 0;
  localparam int ST_PD_BIT = 1;
  localparam int ST_RAMBLK_BIT = 2;
  localparam int ST_IRQWAKE_BIT = 3;
  localparam int ST_INTRST_BIT = 4;

  // ========================================================
  // reset values applied by the internal reset sequence
  // ========================================================
  localparam logic [7:0] PORT_LATCH_RST = 8'hFF;
  localparam logic [7:0] STACK_PTR_RST = 8'h07;

  // ========================================================
  // machine cycle timing, counted in oscillator periods
  // ========================================================
  localparam int CLK_PER_MC = 12;
  localparam logic [3:0] MC_LAST = 4'hB;
  // fifth state, second phase: index 9 of 0..11
  localparam logic [3:0] S5P2_IDX = 4'h9;
  localparam logic [1:0] RST_SAMPLES = 2'h2;

  // ========================================================
  // controller states
  // ========================================================
  typedef enum logic [2:0] {
    ST_RUN,
    ST_IDLE,
    ST_PDOWN,
    ST_WAKE,
    ST_INTRST
  } psm_state_e;

endpackage : psm_pkg

// [psm_rst_if.sv]
`timescale 1ns/1ps
// ==========================================================
// carrier between the controller and the reset pin sampler
// ==========================================================
interface psm_rst_if;
  logic osc_run;
  logic pin_high;
  logic sample_strobe;
  logic rst_confirmed;

  modport ctrl (
    output osc_run,
    input pin_high,
    input sample_strobe,
    input rst_confirmed
  );

  modport sampler (
    input osc_run,
    output pin_high,
    output sample_strobe,
    output rst_confirmed
  );
endinterface : psm_rst_if

// [psm_rst_sampler.sv]
`timescale 1ns/1ps
// ==========================================================
// reset pin synchroniser and machine cycle sampler
// ==========================================================
module psm_rst_sampler (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // raw pin
  input wire logic rst_pin,
  // controller side
  psm_rst_if.sampler rif
);

  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic level_reg;
  logic [3:0] phase_reg;
  logic strobe_reg;
  logic [1:0] hits_reg;

  // three stages; only stage two reads stage one
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= rst_pin;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // level only moves once stages two and three agree
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      level_reg <= 1'b0;
    end else if (sync2_reg == sync3_reg) begin
      level_reg <= sync3_reg;
    end
  end

  // machine cycle phase; frozen while the oscillator is stopped
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase_reg <= 4'h0;
      strobe_reg <= 1'b0;
    end else if (rif.osc_run) begin
      phase_reg <= (phase_reg == psm_pkg::MC_LAST) ? 4'h0 : phase_reg + 4'h1;
      strobe_reg <= (phase_reg == psm_pkg::S5P2_IDX);
    end else begin
      strobe_reg <= 1'b0;
    end
  end

  // count consecutive high samples, one per machine cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hits_reg <= 2'h0;
    end else if (!level_reg) begin
      hits_reg <= 2'h0;
    end else if (strobe_reg && hits_reg != psm_pkg::RST_SAMPLES) begin
      hits_reg <= hits_reg + 2'h1;
    end
  end

  assign rif.pin_high = level_reg;
  assign rif.sample_strobe = strobe_reg;
  // confirmed after two machine cycles high
  assign rif.rst_confirmed = (hits_reg == psm_pkg::RST_SAMPLES);

endmodule : psm_rst_sampler

// [psm_ctrl.sv]
`timescale 1ns/1ps
module psm_ctrl (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // cpu core and interrupt logic
  input wire logic instr_done,
  input wire logic irq_pending,
  // external reset pin
  input wire logic rst_pin,
  // clock gating
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic osc_run,
  // pins and strobes
  output logic port_freeze,
  output logic strobe_override,
  output logic strobe_level,
  // memory and register reset
  output logic ram_block,
  output logic sfr_reset,
  output logic [7:0] port_latch_init,
  output logic [7:0] sp_init,
  // general flags
  output logic [1:0] gen_flags
);

  // ========================================================
  // declarations
  // ========================================================
  psm_pkg::psm_state_e state_reg;
  psm_pkg::psm_state_e state_next;
  logic [3:0] pctrl_reg;
  logic irq_wake_reg;
  logic wr_go;
  logic rd_go;
  logic wr_allowed;
  logic [31:0] rd_mux;

  psm_rst_if rif ();

  // address match used by both read and write decode
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]);
  endfunction : hit

  // ========================================================
  // reset pin sampler
  // ========================================================
  psm_rst_sampler u_sampler (
    .clk(clk),
    .sys_rst(sys_rst),
    .rst_pin(rst_pin),
    .rif(rif.sampler)
  );

  // the oscillator runs in every state but power-down
  assign rif.osc_run = (state_reg != psm_pkg::ST_PDOWN);

  // ========================================================
  // wishbone slave
  // ========================================================
  assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign rd_go = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  // cpu halted or registers under reset: control register writes dropped but acked
  assign wr_allowed = (state_reg == psm_pkg::ST_RUN) || (state_reg == psm_pkg::ST_WAKE);

  // one-cycle answer; drops in the cycle after it was given
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // read mux; unmapped addresses read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit(wb_adr_i, psm_pkg::PCTRL_OFF)) begin
      rd_mux[3:0] = pctrl_reg;
    end else if (hit(wb_adr_i, psm_pkg::PSTAT_OFF)) begin
      rd_mux[psm_pkg::ST_IDLE_BIT] = (state_reg == psm_pkg::ST_IDLE);
      rd_mux[psm_pkg::ST_PD_BIT] = (state_reg == psm_pkg::ST_PDOWN);
      rd_mux[psm_pkg::ST_RAMBLK_BIT] = (state_reg == psm_pkg::ST_WAKE);
      rd_mux[psm_pkg::ST_IRQWAKE_BIT] = irq_wake_reg;
      rd_mux[psm_pkg::ST_INTRST_BIT] = (state_reg == psm_pkg::ST_INTRST);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_go) begin
      wb_dat_o <= rd_mux;
    end
  end

  // ========================================================
  // power control register
  // ========================================================
  // hardware clears of the mode bits beat a same-cycle write
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pctrl_reg <= psm_pkg::PCTRL_RST;
    end else if (state_reg == psm_pkg::ST_INTRST) begin
      pctrl_reg <= psm_pkg::PCTRL_RST;
    end else if (state_reg == psm_pkg::ST_IDLE && rif.pin_high) begin
      pctrl_reg[psm_pkg::IDLE_BIT] <= 1'b0;
    end else if (state_reg == psm_pkg::ST_IDLE && irq_pending) begin
      pctrl_reg[psm_pkg::IDLE_BIT] <= 1'b0;
    end else if (state_reg == psm_pkg::ST_PDOWN && rif.pin_high) begin
      pctrl_reg[psm_pkg::PD_BIT] <= 1'b0;
    end else if (wr_go && wr_allowed && wb_sel_i[0] && hit(wb_adr_i, psm_pkg::PCTRL_OFF)) begin
      // flags land in the same write that requests a mode
      pctrl_reg <= wb_dat_i[3:0];
    end
  end

  // sticky wake-by-interrupt flag, write one to clear, set wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_wake_reg <= 1'b0;
    end else if (state_reg == psm_pkg::ST_IDLE && irq_pending && !rif.pin_high) begin
      irq_wake_reg <= 1'b1;
    end else if (wr_go && wb_sel_i[0] && hit(wb_adr_i, psm_pkg::PSTAT_OFF)
                 && wb_dat_i[psm_pkg::ST_IRQWAKE_BIT]) begin
      irq_wake_reg <= 1'b0;
    end
  end

  // ========================================================
  // mode sequencer
  // ========================================================
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      psm_pkg::ST_RUN: begin
        if (rif.rst_confirmed) begin
          state_next = psm_pkg::ST_INTRST;
        end else if (instr_done && pctrl_reg[psm_pkg::PD_BIT]) begin
          state_next = psm_pkg::ST_PDOWN;
        end else if (instr_done && pctrl_reg[psm_pkg::IDLE_BIT]) begin
          state_next = psm_pkg::ST_IDLE;
        end
      end
      psm_pkg::ST_IDLE: begin
        if (rif.pin_high) begin
          state_next = psm_pkg::ST_WAKE;
        end else if (irq_pending) begin
          // cpu resumes with pc intact; the core vectors and returns
          state_next = psm_pkg::ST_RUN;
        end
      end
      psm_pkg::ST_PDOWN: begin
        // interrupts are ignored; only the pin restarts the oscillator
        if (rif.pin_high) begin
          state_next = psm_pkg::ST_WAKE;
        end
      end
      psm_pkg::ST_WAKE: begin
        // cpu runs a few machine cycles until the pin is confirmed
        if (rif.rst_confirmed) begin
          state_next = psm_pkg::ST_INTRST;
        end else if (!rif.pin_high) begin
          state_next = psm_pkg::ST_RUN;
        end
      end
      psm_pkg::ST_INTRST: begin
        if (!rif.pin_high) begin
          state_next = psm_pkg::ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= psm_pkg::ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // ========================================================
  // registered outputs; all but the general flags and init values taken from the next state
  // ========================================================
  // gating the cpu clock freezes sp, pc, flags word and acc alike
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cpu_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      osc_run <= 1'b1;
    end else begin
      cpu_clk_en <= (state_next != psm_pkg::ST_IDLE)
                    && (state_next != psm_pkg::ST_PDOWN);
      periph_clk_en <= (state_next != psm_pkg::ST_PDOWN);
      osc_run <= (state_next != psm_pkg::ST_PDOWN);
    end
  end

  // pin and strobe control; power-down leaves ports on their latches
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port_freeze <= 1'b0;
      strobe_override <= 1'b0;
      strobe_level <= 1'b0;
    end else begin
      port_freeze <= (state_next == psm_pkg::ST_IDLE);
      strobe_override <= (state_next == psm_pkg::ST_IDLE)
                         || (state_next == psm_pkg::ST_PDOWN);
      strobe_level <= (state_next == psm_pkg::ST_IDLE);
    end
  end

  // ram locked out in the window before internal reset; ports stay open
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ram_block <= 1'b0;
      sfr_reset <= 1'b0;
      port_latch_init <= psm_pkg::PORT_LATCH_RST;
      sp_init <= psm_pkg::STACK_PTR_RST;
      gen_flags <= 2'h0;
    end else begin
      ram_block <= (state_next == psm_pkg::ST_WAKE);
      // ram has no reset path here; only registers are reloaded
      sfr_reset <= (state_next == psm_pkg::ST_INTRST);
      port_latch_init <= psm_pkg::PORT_LATCH_RST;
      sp_init <= psm_pkg::STACK_PTR_RST;
      gen_flags <= {pctrl_reg[psm_pkg::GF1_BIT], pctrl_reg[psm_pkg::GF0_BIT]};
    end
  end

  // ========================================================
  // assertions
  // ========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // idle entry, hold and exit by interrupt
  idle_entry_a: assert property (state_reg == psm_pkg::ST_RUN && !rif.rst_confirmed
    && instr_done && pctrl_reg[psm_pkg::IDLE_BIT] && !pctrl_reg[psm_pkg::PD_BIT]
    |=> state_reg == psm_pkg::ST_IDLE && !cpu_clk_en)
    else $error("idle not entered after instruction");
  idle_clock_a: assert property (state_reg == psm_pkg::ST_IDLE
    |-> !cpu_clk_en && periph_clk_en && osc_run)
    else $error("idle clock gating wrong");
  idle_hold_a: assert property (state_reg == psm_pkg::ST_IDLE && !irq_pending
    && !rif.pin_high |=> $stable(pctrl_reg) && !cpu_clk_en)
    else $error("cpu state not held in idle");
  idle_pins_a: assert property (state_reg == psm_pkg::ST_IDLE
    |-> port_freeze && strobe_override && strobe_level)
    else $error("idle pin state wrong");
  irq_wake_a: assert property (state_reg == psm_pkg::ST_IDLE && irq_pending
    && !rif.pin_high
    |=> state_reg == psm_pkg::ST_RUN && !pctrl_reg[psm_pkg::IDLE_BIT] && cpu_clk_en)
    else $error("interrupt did not end idle");
  irq_flag_a: assert property (state_reg == psm_pkg::ST_IDLE && irq_pending
    && !rif.pin_high |=> irq_wake_reg)
    else $error("interrupt wake not recorded");
  irq_resume_a: assert property (state_reg == psm_pkg::ST_IDLE && irq_pending
    && !rif.pin_high |=> !port_freeze && !strobe_override && !sfr_reset && !ram_block)
    else $error("interrupt wake did not resume plainly");
  flag_write_a: assert property (wr_go && wr_allowed && wb_sel_i[0] && !rif.pin_high
    && state_reg == psm_pkg::ST_RUN && hit(wb_adr_i, psm_pkg::PCTRL_OFF)
    |=> ##1 gen_flags == $past(wb_dat_i[3:2], 2))
    else $error("general flags not stored");

  // reset pin wake, run window and internal reset
  rst_idle_a: assert property (state_reg == psm_pkg::ST_IDLE && rif.pin_high
    |=> !pctrl_reg[psm_pkg::IDLE_BIT] && ram_block && cpu_clk_en)
    else $error("reset pin did not clear idle");
  wake_window_a: assert property (state_reg == psm_pkg::ST_WAKE
    |-> ram_block && cpu_clk_en && !port_freeze && !sfr_reset)
    else $error("run window before internal reset wrong");
  rst_regs_a: assert property (state_reg == psm_pkg::ST_INTRST
    |-> sfr_reset && !ram_block)
    else $error("internal reset outputs wrong");
  int_rst_a: assert property (state_reg == psm_pkg::ST_INTRST
    |=> pctrl_reg == psm_pkg::PCTRL_RST && $past(sfr_reset))
    else $error("internal reset did not clear registers");

  // power-down entry, hold and exit
  pd_entry_a: assert property (state_reg == psm_pkg::ST_RUN && !rif.rst_confirmed
    && instr_done && pctrl_reg[psm_pkg::PD_BIT]
    |=> state_reg == psm_pkg::ST_PDOWN)
    else $error("power-down not entered");
  pd_wins_a: assert property (state_reg == psm_pkg::ST_RUN && !rif.rst_confirmed
    && instr_done && pctrl_reg[psm_pkg::IDLE_BIT] && pctrl_reg[psm_pkg::PD_BIT]
    |=> state_reg == psm_pkg::ST_PDOWN && !osc_run)
    else $error("idle won over power-down");
  osc_stop_a: assert property (state_reg == psm_pkg::ST_PDOWN
    |=> !rif.sample_strobe)
    else $error("machine cycle ran in power-down");
  pd_pins_a: assert property (state_reg == psm_pkg::ST_PDOWN
    |-> !osc_run && !periph_clk_en && strobe_override && !strobe_level)
    else $error("power-down outputs wrong");
  pd_noirq_a: assert property (state_reg == psm_pkg::ST_PDOWN && !rif.pin_high
    |=> state_reg == psm_pkg::ST_PDOWN)
    else $error("power-down left without reset");

  // reset pin sampling, once per machine cycle
  rst_sample_a: assert property ($rose(rif.rst_confirmed)
    |-> $past(rif.sample_strobe))
    else $error("reset confirmed off the sample point");
  sample_gap_a: assert property (rif.sample_strobe
    |=> !rif.sample_strobe [*8])
    else $error("reset pin sampled too often");

  bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer timing wrong");

  idle_irq_c: cover property (state_reg == psm_pkg::ST_IDLE ##1 state_reg == psm_pkg::ST_RUN);
  idle_rst_c: cover property (state_reg == psm_pkg::ST_WAKE ##[1:60] sfr_reset);
  pd_exit_c: cover property (state_reg == psm_pkg::ST_PDOWN ##1 state_reg == psm_pkg::ST_WAKE);
  both_bits_c: cover property (instr_done && pctrl_reg[1:0] == 2'h3
    && state_reg == psm_pkg::ST_RUN);
  run_rst_c: cover property (state_reg == psm_pkg::ST_RUN ##1 state_reg == psm_pkg::ST_INTRST);

endmodule : psm_ctrl

// [psm_cpu_model.sv]
`timescale 1ns/1ps
// ==========================================================
// cpu core, interrupt source and reset source stand-in
// ==========================================================
module psm_cpu_model (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // block outputs seen by the core
  input wire logic cpu_clk_en,
  // bench commands
  input wire logic irq_req,
  input wire logic rst_go,
  input wire logic [7:0] rst_len,
  // towards the block
  output logic instr_done,
  output logic irq_pending,
  output logic rst_pin
);
  logic [1:0] ins_cnt;
  logic [7:0] hold_cnt;

  // an instruction finishes every fourth cycle while the core is clocked
  always_ff @(posedge clk) begin
    if (sys_rst || !cpu_clk_en) begin
      ins_cnt <= 2'h0;
    end else begin
      ins_cnt <= ins_cnt + 2'h1;
    end
  end
  assign instr_done = cpu_clk_en && (ins_cnt == 2'h3);

  // enabled interrupt is a plain level from the bench
  assign irq_pending = irq_req;

  // reset pin held at least two machine cycles, longer when asked
  // cleared by the bench reset so the pin idles low, not unknown
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hold_cnt <= 8'h00;
    end else if (rst_go) begin
      hold_cnt <= (rst_len < 8'h18) ? 8'h18 : rst_len;
    end else if (hold_cnt != 8'h00) begin
      hold_cnt <= hold_cnt - 8'h01;
    end
  end
  // pin has a pull-down, so released means low
  assign rst_pin = (hold_cnt != 8'h00);
endmodule : psm_cpu_model

// [power_save_mode_control_bench.sv]
`timescale 1ns/1ps
// ==========================================================
// bench for the power save mode controller
// ==========================================================
module power_save_mode_control_bench;
  localparam logic [31:0] B_IDLE = 32'h1 << psm_pkg::IDLE_BIT;
  localparam logic [31:0] B_PD = 32'h1 << psm_pkg::PD_BIT;
  localparam logic [31:0] B_GF = (32'h1 << psm_pkg::GF0_BIT) | (32'h1 << psm_pkg::GF1_BIT);
  localparam logic [31:0] B_WAKE = 32'h1 << psm_pkg::ST_IRQWAKE_BIT;
  logic clk, sys_rst, cyc, stb, we, ack, instr_done, irq_pending, rst_pin;
  logic [7:0] adr, pl_init, sp_init, rst_len;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r, q;
  logic cpu_en, per_en, osc_run, freeze, s_ovr, s_lvl, ram_blk, sfr_rst, irq_req, rst_go;
  logic [1:0] gflags;
  int miscompares, num_checks;

  psm_ctrl DUT (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .instr_done(instr_done), .irq_pending(irq_pending), .rst_pin(rst_pin),
    .cpu_clk_en(cpu_en), .periph_clk_en(per_en), .osc_run(osc_run), .port_freeze(freeze),
    .strobe_override(s_ovr), .strobe_level(s_lvl), .ram_block(ram_blk), .sfr_reset(sfr_rst),
    .port_latch_init(pl_init), .sp_init(sp_init), .gen_flags(gflags));

  psm_cpu_model cpu (.clk(clk), .sys_rst(sys_rst), .cpu_clk_en(cpu_en), .irq_req(irq_req),
    .rst_go(rst_go), .rst_len(rst_len), .instr_done(instr_done),
    .irq_pending(irq_pending), .rst_pin(rst_pin));

  // ========================================================
  // clock, shared tasks
  // ========================================================
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  // one classic cycle; ack is seen as it stood before the edge
  // no limit of its own: only the watchdog ends a hung wait
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask : bus

  function logic pick(input int k);
    case (k)
      0: pick = cpu_en;
      1: pick = osc_run;
      2: pick = ram_blk;
      default: pick = sfr_rst;
    endcase
  endfunction : pick

  // bounded wait for a block output to reach a level
  task wait_on(input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (pick(k) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    check("wait", {31'h0, pick(k)}, {31'h0, v});
  endtask : wait_on

  task pin_pulse(input logic [7:0] len);
    rst_len <= len;
    rst_go <= 1'b1;
    @(posedge clk);
    rst_go <= 1'b0;
  endtask : pin_pulse

  // ========================================================
  // watchdog: whole run is a few hundred cycles
  // ========================================================
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    complete_run();
  end

  // ========================================================
  // scenarios
  // ========================================================
  initial begin
    miscompares = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    {cyc, stb, we, irq_req, rst_go} = 5'h00;
    adr = 8'h00;
    sel = 4'hF;
    dat_w = 32'h0;
    rst_len = 8'h00;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    // reset values and an unmapped read
    check("latch_init", {24'h0, pl_init}, {24'h0, psm_pkg::PORT_LATCH_RST});
    check("sp_init", {24'h0, sp_init}, {24'h0, psm_pkg::STACK_PTR_RST});
    check("clocks", {29'h0, cpu_en, per_en, osc_run}, 32'h7);
    bus(1'b0, 8'h40, 32'h0);
    check("unmapped", q, 32'h0);
    // idle entered in the same write that sets both flags
    bus(1'b1, psm_pkg::PCTRL_OFF, B_IDLE | B_GF);
    wait_on(0, 1'b0, 40);
    check("flags", {30'h0, gflags}, 32'h3);
    check("idle_clk", {30'h0, per_en, osc_run}, 32'h3);
    check("idle_pins", {29'h0, freeze, s_ovr, s_lvl}, 32'h7);
    bus(1'b0, psm_pkg::PSTAT_OFF, 32'h0);
    check("idle_stat", q & 32'h1F, 32'h1);
    bus(1'b1, psm_pkg::PCTRL_OFF, 32'h0);
    bus(1'b0, psm_pkg::PCTRL_OFF, 32'h0);
    check("idle_ignore", q, B_IDLE | B_GF);
    // interrupt ends idle, flags survive
    irq_req <= 1'b1;
    wait_on(0, 1'b1, 40);
    irq_req <= 1'b0;
    check("wake_pins", {30'h0, freeze, s_ovr}, 32'h0);
    bus(1'b0, psm_pkg::PCTRL_OFF, 32'h0);
    check("wake_pctrl", q, B_GF);
    bus(1'b0, psm_pkg::PSTAT_OFF, 32'h0);
    check("wake_stat", q & B_WAKE, B_WAKE);
    bus(1'b1, psm_pkg::PSTAT_OFF, B_WAKE);
    bus(1'b0, psm_pkg::PSTAT_OFF, 32'h0);
    check("wake_clr", q & B_WAKE, 32'h0);
    // both bits: power-down wins, interrupt cannot wake
    bus(1'b1, psm_pkg::PCTRL_OFF, B_IDLE | B_PD);
    wait_on(1, 1'b0, 40);
    check("pd_clk", {30'h0, cpu_en, per_en}, 32'h0);
    check("pd_pins", {29'h0, freeze, s_ovr, s_lvl}, 32'h2);
    bus(1'b0, psm_pkg::PSTAT_OFF, 32'h0);
    check("pd_stat", q & 32'h1F, 32'h2);
    irq_req <= 1'b1;
    repeat (40) @(posedge clk);
    check("pd_irq", {31'h0, osc_run}, 32'h0);
    irq_req <= 1'b0;
    pin_pulse(8'h3C);
    wait_on(1, 1'b1, 20);
    wait_on(3, 1'b1, 80);
    wait_on(3, 1'b0, 80);
    bus(1'b0, psm_pkg::PCTRL_OFF, 32'h0);
    check("pd_reset", q, 32'h0);
    // reset pin ends idle; ram blocked, ports free, then internal reset
    bus(1'b1, psm_pkg::PCTRL_OFF, B_IDLE);
    wait_on(0, 1'b0, 40);
    pin_pulse(8'h30);
    wait_on(2, 1'b1, 20);
    check("run_window", {30'h0, cpu_en, freeze}, 32'h2);
    bus(1'b0, psm_pkg::PSTAT_OFF, 32'h0);
    check("ram_stat", q & 32'h1F, 32'h4);
    wait_on(3, 1'b1, 80);
    check("ram_free", {31'h0, ram_blk}, 32'h0);
    wait_on(3, 1'b0, 80);
    bus(1'b0, psm_pkg::PCTRL_OFF, 32'h0);
    check("idle_reset", q, 32'h0);
    // shortest legal pin pulse while running goes straight to internal reset
    bus(1'b1, psm_pkg::PCTRL_OFF, B_GF);
    pin_pulse(8'h00);
    wait_on(3, 1'b1, 80);
    check("run_rst", {30'h0, cpu_en, ram_blk}, 32'h2);
    wait_on(3, 1'b0, 80);
    bus(1'b0, psm_pkg::PCTRL_OFF, 32'h0);
    check("run_rst_pctrl", q, 32'h0);
    check("run_rst_flags", {30'h0, gflags}, 32'h0);
    complete_run();
  end
endmodule : power_save_mode_control_bench
